// [core/time_of_day_unit.sv]
// time-of-day unit: bcd clock, calendar, alarm, drift trim
// Summary of operation
// [R1] control, alarm control, time, date and alarm time/date registers also at +0x4 clear, +0x8 set, +0xC toggle
// [R2] seconds, minutes, hours kept as bcd digit pairs, 24-hour
// [R3] half-second flag readable in the control register
// [R4] weekday, day, month, year with month-length day limits
// [R5] years 00..99 in bcd, february gets day 29 in leap years
// [R6] alarm interval from half second up to once a year
// [R7] repeat count drops by one on each alarm event, except at count zero without chime
// [R8] chime mode lets repeat count wrap and alarms continue
// [R9] drift trim applied automatically, covering 260 ppm
// [R10] second ticks counted from 32.768 kHz crystal edges
// [R11] output pin carries alarm pulse or seconds clock
// [R12] control and alarm control registers reset to zero
// [R13] enable bit writable only while write unlock is set
// [R14] signed 10-bit trim adds or drops pulses each minute
// [R15] alarm enable cleared on event at count zero without chime
// [R16] half-second flag cleared by a write to the time register
// [R17] weekday advances each day, 0 to 6 then back to 0
`timescale 1ns/1ps
module time_of_day_unit
  import rtc_pkg::*;
#(
  parameter int HALF_COUNT = HALF_PULSES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic XTAL_IN,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic RTC_OUT
);
  // parameter range check
  if (HALF_COUNT < 1024 || HALF_COUNT > 65535) begin : g_chk
    $error("HALF_COUNT out of range");
  end

  localparam logic signed [16:0] HALF_LAST = 17'(HALF_COUNT - 1);
  localparam logic signed [16:0] SYNC_AT = 17'(HALF_COUNT - SYNC_WIN);

  // bcd increment with wrap: {wrapped, next}
  function automatic logic [8:0] inc2(input logic [7:0] v,
      input logic [7:0] top, input logic [7:0] low);
    if (v >= top) inc2 = {1'b1, low};
    else if (v[3:0] == 4'h9) inc2 = {1'b0, v[7:4] + 4'h1, 4'h0};
    else inc2 = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : inc2

  // last day of a month in bcd
  function automatic logic [7:0] last_day(input logic [7:0] mon,
      input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    case (mon)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  // plain write or alias operation
  function automatic logic [31:0] apply(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] op);
    case (op) // [R1]
      OP_CLR: apply = old & ~d;
      OP_SET: apply = old | d;
      OP_INV: apply = old ^ d;
      default: apply = d;
    endcase
  endfunction : apply

  logic rs1_reg, rst_n;
  logic xs1_reg, xs2_reg, xs3_reg;
  logic signed [16:0] presc_reg;
  logic half_reg, pulse_reg;
  logic [31:0] ctrl_reg, alm_reg, time_reg, date_reg;
  logic [31:0] atime_reg, adate_reg;
  logic [1:0] stat_reg, ien_reg;
  logic [31:0] time_next, date_next;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  // bus decode
  wire [15:0] base = {ADDR[15:4], 4'h0};
  wire [3:0] op = ADDR[3:0];
  wire op_ok = (ADDR[1:0] == 2'b00);
  wire wren = ctrl_reg[WREN_BIT];
  wire on = ctrl_reg[ON_BIT];
  wire w_ctrl = WR && op_ok && base == CTRL_OFS;
  wire w_alm = WR && op_ok && base == ALMCTL_OFS;
  wire w_time = WR && op_ok && base == TIME_OFS && wren;
  wire w_date = WR && op_ok && base == DATE_OFS && wren;
  wire w_atime = WR && op_ok && base == ATIME_OFS;
  wire w_adate = WR && op_ok && base == ADATE_OFS;
  wire w_iclr = WR && op == OP_WR && base == ICLR_OFS;
  wire w_ien = WR && op == OP_WR && base == IEN_OFS;

  // crystal edge detect after two sync flops
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
    end else begin
      xs1_reg <= XTAL_IN;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
    end
  end
  wire xt_edge = xs2_reg && !xs3_reg;

  wire half_tick = on && xt_edge && presc_reg >= HALF_LAST; // [R10]
  wire sec_tick = half_tick && half_reg;
  wire min_roll = sec_tick && time_reg[SEC_LSB+:8] >= 8'h59;
  wire signed [16:0] cal_ext = 17'($signed(ctrl_reg[CAL_LSB+:10]));
  wire near_roll = on && presc_reg >= SYNC_AT;

  // prescaler, trim loaded at each minute start
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 17'sd0;
    end else if (half_tick) begin
      presc_reg <= min_roll ? cal_ext : 17'sd0; // [R9] [R14]
    end else if (on && xt_edge) begin
      presc_reg <= presc_reg + 17'sd1; // [R10]
    end
  end

  // half-second flag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else if (w_time) begin
      half_reg <= 1'b0; // [R16]
    end else if (half_tick) begin
      half_reg <= !half_reg; // [R3]
    end
  end

  // rollover cascade
  always_comb begin
    logic [8:0] s, m, h, d, mo, y;
    s = inc2(time_reg[SEC_LSB+:8], 8'h59, 8'h00); // [R2]
    m = inc2(time_reg[MIN_LSB+:8], 8'h59, 8'h00);
    h = inc2(time_reg[HR_LSB+:8], 8'h23, 8'h00);
    d = inc2(date_reg[DAY_LSB+:8], last_day(date_reg[MON_LSB+:8],
        date_reg[YR_LSB+:8]), 8'h01); // [R4] [R5]
    mo = inc2(date_reg[MON_LSB+:8], 8'h12, 8'h01);
    y = inc2(date_reg[YR_LSB+:8], 8'h99, 8'h00); // [R5]
    time_next = time_reg;
    date_next = date_reg;
    time_next[SEC_LSB+:8] = s[7:0];
    if (s[8]) time_next[MIN_LSB+:8] = m[7:0];
    if (s[8] && m[8]) time_next[HR_LSB+:8] = h[7:0];
    if (s[8] && m[8] && h[8]) begin
      date_next[DAY_LSB+:8] = d[7:0];
      date_next[2:0] = (date_reg[2:0] >= 3'd6) ? 3'd0
                       : date_reg[2:0] + 3'd1; // [R17]
      if (d[8]) date_next[MON_LSB+:8] = mo[7:0];
      if (d[8] && mo[8]) date_next[YR_LSB+:8] = y[7:0];
    end
  end

  // current time and date, bus write wins over count
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= 32'h0000_0000;
      date_reg <= 32'h0000_0000;
    end else begin
      if (w_time) time_reg <= apply(time_reg, WDATA, op) & TIME_MASK;
      else if (sec_tick) time_reg <= time_next & TIME_MASK;
      if (w_date) date_reg <= apply(date_reg, WDATA, op) & DATE_MASK;
      else if (sec_tick) date_reg <= date_next & DATE_MASK;
    end
  end

  // alarm time and date
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      atime_reg <= 32'h0000_0000;
      adate_reg <= 32'h0000_0000;
    end else begin
      if (w_atime) atime_reg <= apply(atime_reg, WDATA, op) & TIME_MASK;
      if (w_adate) adate_reg <= apply(adate_reg, WDATA, op) & ADATE_MASK;
    end
  end

  // alarm match against the time being entered
  wire [3:0] amask = alm_reg[AMASK_LSB+:4];
  wire [7:0] rpt = alm_reg[7:0];
  wire alen = alm_reg[ALEN_BIT];
  wire chime = alm_reg[CHIME_BIT];
  wire eq_s1 = time_next[SEC_LSB+:4] == atime_reg[SEC_LSB+:4];
  wire eq_s = time_next[SEC_LSB+:8] == atime_reg[SEC_LSB+:8];
  wire eq_m1 = time_next[MIN_LSB+:4] == atime_reg[MIN_LSB+:4];
  wire eq_m = time_next[MIN_LSB+:8] == atime_reg[MIN_LSB+:8];
  wire eq_h = time_next[HR_LSB+:8] == atime_reg[HR_LSB+:8];
  wire eq_w = date_next[2:0] == adate_reg[2:0];
  wire eq_d = date_next[DAY_LSB+:8] == adate_reg[DAY_LSB+:8];
  wire eq_mo = date_next[MON_LSB+:8] == adate_reg[MON_LSB+:8];
  logic hit;
  always_comb begin
    case (amask) // [R6]
      4'h0: hit = 1'b1;
      4'h1: hit = half_reg;
      4'h2: hit = half_reg && eq_s1;
      4'h3: hit = half_reg && eq_s;
      4'h4: hit = half_reg && eq_s && eq_m1;
      4'h5: hit = half_reg && eq_s && eq_m;
      4'h6: hit = half_reg && eq_s && eq_m && eq_h;
      4'h7: hit = half_reg && eq_s && eq_m && eq_h && eq_w;
      4'h8: hit = half_reg && eq_s && eq_m && eq_h && eq_d;
      4'h9: hit = half_reg && eq_s && eq_m && eq_h && eq_d && eq_mo;
      default: hit = 1'b0;
    endcase
  end
  wire fire = half_tick && alen && hit;

  // control register, enable bit locked unless unlocked
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST; // [R12]
    end else if (w_ctrl) begin
      ctrl_reg <= apply(ctrl_reg, WDATA, op) & CTRL_MASK;
      if (!wren) ctrl_reg[ON_BIT] <= ctrl_reg[ON_BIT]; // [R13]
    end
  end

  // alarm control with repeat count
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      alm_reg <= ALM_RST; // [R12]
    end else if (w_alm) begin
      alm_reg <= apply(alm_reg, WDATA, op) & ALM_MASK;
    end else if (fire) begin
      if (rpt == 8'h00 && !chime) alm_reg[ALEN_BIT] <= 1'b0; // [R15]
      else alm_reg[7:0] <= rpt - 8'h01; // [R7] [R8]
    end
  end

  // alarm pulse, preset while alarm is off
  wire [31:0] alm_new = apply({alm_reg[31:14], pulse_reg,
      alm_reg[12:0]}, WDATA, op);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else if (w_alm && !alen) begin
      pulse_reg <= alm_new[PIV_BIT];
    end else if (fire) begin
      pulse_reg <= !pulse_reg;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= ST_RST;
      ien_reg <= ST_RST;
      IRQ <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~(w_iclr ? WDATA[1:0] : 2'b00)) |
                  {sec_tick, fire};
      if (w_ien) ien_reg <= WDATA[1:0];
      IRQ <= |(stat_reg & ien_reg);
    end
  end

  // output pin source
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RTC_OUT <= 1'b0;
    end else begin
      RTC_OUT <= ctrl_reg[OE_BIT] && (ctrl_reg[SECSEL_BIT] ? !half_reg
                 : pulse_reg); // [R11]
    end
  end

  // read data, one cycle after the strobe
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (base)
      CTRL_OFS: begin
        rmux = ctrl_reg;
        rmux[CLKON_BIT] = on;
        rmux[SYNC_BIT] = near_roll;
        rmux[HALF_BIT] = half_reg; // [R3]
      end
      ALMCTL_OFS: begin
        rmux = alm_reg;
        rmux[PIV_BIT] = pulse_reg;
        rmux[ASYNC_BIT] = near_roll;
      end
      TIME_OFS: rmux = time_reg;
      DATE_OFS: rmux = date_reg;
      ATIME_OFS: rmux = atime_reg;
      ADATE_OFS: rmux = adate_reg;
      STAT_OFS: rmux = {30'h0, stat_reg};
      IEN_OFS: rmux = {30'h0, ien_reg};
      default: rmux = 32'h0000_0000;
    endcase
    if (!op_ok || base == ICLR_OFS) rmux = 32'h0000_0000;
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= 32'h0000_0000;
    else RDATA <= RD ? rmux : 32'h0000_0000;
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  alias_set_a: assert property ((w_alm && op == OP_SET) |=> // [R1]
      ((alm_reg & $past(WDATA) & 32'h0000_0FFF) ==
       ($past(WDATA) & 32'h0000_0FFF)))
    else $error("set alias lost bits");
  sec_wrap_a: assert property ((sec_tick && !w_time && // [R2]
      time_reg[SEC_LSB+:8] == 8'h59) |=> time_reg[SEC_LSB+:8] == 8'h00)
    else $error("seconds did not wrap");
  half_clr_a: assert property (w_time |=> !half_reg) // [R16]
    else $error("half flag not cleared");
  feb_end_a: assert property ((sec_tick && !w_date && // [R5]
      time_next[HR_LSB+:8] == 8'h00 && time_reg[HR_LSB+:8] == 8'h23 &&
      date_reg[MON_LSB+:8] == 8'h02 && date_reg[YR_LSB+:8] == 8'h01 &&
      date_reg[DAY_LSB+:8] == 8'h28) |=> date_reg[DAY_LSB+:8] == 8'h01)
    else $error("february end wrong");
  wday_wrap_a: assert property ((sec_tick && !w_date && // [R17]
      time_reg[HR_LSB+:8] == 8'h23 && time_next[HR_LSB+:8] == 8'h00 &&
      date_reg[2:0] == 3'd6) |=> date_reg[2:0] == 3'd0)
    else $error("weekday did not wrap");
  rpt_dec_a: assert property ((fire && !w_alm && rpt != 8'h00) // [R7]
      |=> alm_reg[7:0] == $past(rpt) - 8'h01 && alen)
    else $error("repeat count not decremented");
  chime_wrap_a: assert property ((fire && !w_alm && rpt == 8'h00 &&
      chime) |=> alm_reg[7:0] == 8'hFF && alen) // [R8]
    else $error("chime did not wrap");
  alarm_off_a: assert property ((fire && !w_alm && rpt == 8'h00 &&
      !chime) |=> !alen) // [R15]
    else $error("alarm enable not cleared");
  on_lock_a: assert property ((w_ctrl && !wren) |=> $stable(on)) // [R13]
    else $error("enable changed while locked");
  cal_load_a: assert property (min_roll |=> presc_reg == // [R14]
      $past(cal_ext))
    else $error("trim not loaded");
  tick_edge_a: assert property (half_tick |-> xt_edge && on // [R10]
      && $past(presc_reg) == HALF_LAST)
    else $error("half tick without count");
  mask_sec_a: assert property ((fire && amask != 4'h0) |-> // [R6]
      half_reg) else $error("alarm off the second boundary");
  pin_sel_a: assert property (##1 RTC_OUT == $past(ctrl_reg[OE_BIT] &&
      (ctrl_reg[SECSEL_BIT] ? !half_reg : pulse_reg))) // [R11]
    else $error("output pin source wrong");

  c_fire: cover property (fire && chime);
  c_minute: cover property (min_roll && cal_ext != 17'sd0);
  c_day: cover property (sec_tick && date_next[2:0] != date_reg[2:0]);
  c_irq: cover property (IRQ && w_iclr);
endmodule : time_of_day_unit

// [shared/rtc_pkg.sv]
// constants shared by the time-of-day unit
package rtc_pkg;
  // register byte offsets
  localparam logic [15:0] CTRL_OFS = 16'h0200;
  localparam logic [15:0] ALMCTL_OFS = 16'h0210;
  localparam logic [15:0] TIME_OFS = 16'h0220;
  localparam logic [15:0] DATE_OFS = 16'h0230;
  localparam logic [15:0] ATIME_OFS = 16'h0240;
  localparam logic [15:0] ADATE_OFS = 16'h0250;
  localparam logic [15:0] STAT_OFS = 16'h0260;
  localparam logic [15:0] ICLR_OFS = 16'h0270;
  localparam logic [15:0] IEN_OFS = 16'h0280;
  // alias offsets inside a register slot
  localparam logic [3:0] OP_WR = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h4;
  localparam logic [3:0] OP_SET = 4'h8;
  localparam logic [3:0] OP_INV = 4'hC;
  // implemented bits of each register
  localparam logic [31:0] CTRL_MASK = 32'h03FF_A089;
  localparam logic [31:0] ALM_MASK = 32'h0000_CFFF;
  localparam logic [31:0] TIME_MASK = 32'h3F7F_7F00;
  localparam logic [31:0] DATE_MASK = 32'hFF1F_3F07;
  localparam logic [31:0] ADATE_MASK = 32'h001F_FF07;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ALM_RST = 32'h0000_0000;
  localparam logic [1:0] ST_RST = 2'h0;
  // control and alarm control fields
  localparam int ON_BIT = 15;
  localparam int SECSEL_BIT = 7;
  localparam int CLKON_BIT = 6;
  localparam int WREN_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int OE_BIT = 0;
  localparam int CAL_LSB = 16;
  localparam int ALEN_BIT = 15;
  localparam int CHIME_BIT = 14;
  localparam int PIV_BIT = 13;
  localparam int ASYNC_BIT = 12;
  localparam int AMASK_LSB = 8;
  // time and date field positions
  localparam int SEC_LSB = 8;
  localparam int MIN_LSB = 16;
  localparam int HR_LSB = 24;
  localparam int DAY_LSB = 8;
  localparam int MON_LSB = 16;
  localparam int YR_LSB = 24;
  // status bits
  localparam int ST_ALARM = 0;
  localparam int ST_SEC = 1;
  // time base
  localparam int XTAL_HZ = 32768;
  localparam int HALF_PULSES = XTAL_HZ / 2;
  localparam int SYNC_WIN = 32;
endpackage : rtc_pkg

// [tb/tb_top.sv]
// self-checking bench for the time-of-day unit over its register port
`timescale 1ns/1ps
module tb_top
  import rtc_pkg::*;
;
  localparam int HC = 1024;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [31:0] WDATA = 32'h0000_0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic XTAL_IN = 1'b0;
  logic [31:0] RDATA;
  logic IRQ;
  logic RTC_OUT;
  int num_errors = 0;
  int checks = 0;
  // dates before and after one midnight: y m d wd
  logic [31:0] din [4] = '{32'h9912_3106, 32'h0002_2801, 32'h0102_2803,
                           32'h0104_3005};
  logic [31:0] dout [4] = '{32'h0001_0100, 32'h0002_2902, 32'h0103_0104,
                            32'h0105_0106};

  time_of_day_unit #(.HALF_COUNT(HC)) uut (
    .CLK(CLK),
    .RSTN(RSTN),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .XTAL_IN(XTAL_IN),
    .RDATA(RDATA),
    .IRQ(IRQ),
    .RTC_OUT(RTC_OUT)
  );

  // 50 MHz system clock
  always #10 CLK = ~CLK;

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [15:0] a,
                      input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, exp, d & m);
  endtask : rchk

  // seconds clock on the pin, high in the first half second
  task automatic pin_chk(input logic e);
    chk("pin", {31'h0, e}, {31'h0, RTC_OUT});
  endtask : pin_chk

  // n crystal periods of 5 clocks, then let the sync chain settle
  task automatic xt(input int n);
    repeat (n) begin
      XTAL_IN <= 1'b1;
      repeat (3) @(posedge CLK);
      XTAL_IN <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    repeat (8) @(posedge CLK);
  endtask : xt

  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // watchdog sized above the expected 89k cycles
  initial begin
    repeat (95000) @(posedge CLK);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    rchk("ctrl", CTRL_OFS, 32'hFFFF_FFFB, CTRL_RST);
    rchk("almctl", ALMCTL_OFS, 32'hFFFF_FFFF, ALM_RST);
    rchk("time_low", TIME_OFS, 32'h0000_00FF, 32'h0);
    rchk("unmapped", 16'h0300, 32'hFFFF_FFFF, 32'h0);
    // enable refused while locked
    wr(CTRL_OFS, 32'h0000_8000);
    rchk("ctrl_lock", CTRL_OFS, 32'hFFFF_FFFB, 32'h0);
    wr({CTRL_OFS[15:4], OP_SET}, 32'h0000_0008);
    rchk("ctrl_set", CTRL_OFS, 32'hFFFF_FFFB, 32'h0000_0008);
    wr({CTRL_OFS[15:4], OP_SET}, 32'h0000_8001);
    rchk("ctrl_on", CTRL_OFS, 32'hFFFF_FFFB, 32'h0000_8049);
    wr({CTRL_OFS[15:4], OP_CLR}, 32'h0000_0001);
    rchk("ctrl_clr", CTRL_OFS, 32'hFFFF_FFFB, 32'h0000_8048);
    wr({CTRL_OFS[15:4], OP_INV}, 32'h0000_0081);
    rchk("ctrl_inv", CTRL_OFS, 32'hFFFF_FFFB, 32'h0000_80C9);
    // half flag rises mid-second, sync bit quiet, a time write drops it
    wr(TIME_OFS, 32'h2359_5900);
    xt(HC + HC / 4);
    rchk("half_hi", CTRL_OFS, 32'h0000_0006, 32'h0000_0002);
    pin_chk(1'b0);
    wr(TIME_OFS, 32'h2359_5900);
    rchk("half_lo", CTRL_OFS, 32'h0000_0002, 32'h0);
    pin_chk(1'b1);
    // midnight rollovers across month, leap and year ends
    for (int i = 0; i < 4; i++) begin
      wr(TIME_OFS, 32'h2359_5900);
      wr(DATE_OFS, din[i]);
      xt(2 * HC + HC / 4);
      rchk("time", TIME_OFS, 32'hFFFF_FFFF, 32'h0);
      rchk("date", DATE_OFS, 32'hFFFF_FFFF, dout[i]);
    end
    // every-half-second alarm counting down twice
    wr(IEN_OFS, 32'h0000_0001);
    wr(ALMCTL_OFS, 32'h0000_8002);
    xt(HC);
    rchk("rpt1", ALMCTL_OFS, 32'h0000_CFFF, 32'h0000_8001);
    rchk("stat", STAT_OFS, 32'h0000_0001, 32'h0000_0001);
    chk("irq_on", 32'h1, {31'h0, IRQ});
    wr(ICLR_OFS, 32'h0000_0001);
    repeat (3) @(posedge CLK);
    chk("irq_clr", 32'h0, {31'h0, IRQ});
    xt(HC);
    rchk("rpt0", ALMCTL_OFS, 32'h0000_CFFF, 32'h0000_8000);
    xt(HC);
    rchk("alm_off", ALMCTL_OFS, 32'h0000_CFFF, 32'h0);
    wr(ICLR_OFS, 32'h0000_0001);
    xt(HC);
    rchk("stat_off", STAT_OFS, 32'h0000_0001, 32'h0);
    // chime lets the count wrap and alarms go on
    wr(ALMCTL_OFS, 32'h0000_C000);
    xt(HC);
    rchk("chime", ALMCTL_OFS, 32'h0000_CFFF, 32'h0000_C0FF);
    chk("irq_chime", 32'h1, {31'h0, IRQ});
    wr(IEN_OFS, 32'h0);
    repeat (3) @(posedge CLK);
    chk("irq_mask", 32'h0, {31'h0, IRQ});
    // every-second alarm fires on the whole second only
    wr(ALMCTL_OFS, 32'h0000_8101);
    xt(2 * HC);
    rchk("mask_sec", ALMCTL_OFS, 32'h0000_CFFF, 32'h0000_8100);
    // pulse preset while the alarm is off, then shown on the pin
    wr(ALMCTL_OFS, 32'h0);
    wr(ALMCTL_OFS, 32'h0000_2000);
    rchk("piv", ALMCTL_OFS, 32'h0000_2000, 32'h0000_2000);
    wr({CTRL_OFS[15:4], OP_INV}, 32'h0000_0080);
    repeat (3) @(posedge CLK);
    chk("pin_pulse", 32'h1, {31'h0, RTC_OUT});
    // output enable off silences the pin
    wr({CTRL_OFS[15:4], OP_CLR}, 32'h0000_0001);
    repeat (3) @(posedge CLK);
    chk("pin_off", 32'h0, {31'h0, RTC_OUT});
    wrap_up();
  end
endmodule : tb_top
